// File: design/stp_ctrl.sv
// stp_ctrl.sv - control core of a dual-bridge stepper driver:
// blanking selection, fault sequencing, sleep, wake and output disable.
// assumes analog comparators on the pins, outside indexer tables
// giving per-bridge sine step codes, and gate drivers that keep
// a bridge Hi-Z while its on level is low.
`timescale 1ns/1ps
`default_nettype none
`include "stp_consts.svh"

module stp_ctrl #(
  parameter int OCP_DEGLITCH_CYC = `STP_OCP_CYC,
  parameter int RETRY_CYC = `STP_RETRY_CYC,
  parameter int SLEEP_CYC = `STP_SLEEP_CYC,
  parameter int WAKE_CYC = `STP_WAKE_CYC,
  parameter int OFF_CYC = `STP_OFF_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // mode and step pins from the controller
  input wire logic sleep_in_low_in,
  input wire logic output_enable_low_in,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic auto_decay_select_in,
  // tri-level select pins, two window comparators each
  input wire logic [1:0] torque_above_in,
  input wire logic [1:0] torque_below_in,
  input wire logic decay_select_hi_above_in,
  input wire logic decay_select_hi_below_in,
  input wire logic decay_select_lo_above_in,
  input wire logic decay_select_lo_below_in,
  // analog monitors
  input wire logic overtemp_in,
  input wire logic motor_supply_under_in,
  input wire logic [1:0] winding_sense_input_in,
  input wire logic [7:0] fet_limit_in,
  // sine step codes from the indexer tables, one per bridge
  input wire logic [1:0][4:0] sine_step_code_in,
  // fault and mode status
  output logic fault_out_low_out,
  output logic internal_regulator_on_out,
  output logic asleep_out,
  // bridge control
  output logic [1:0] bridge_on_out,
  output logic [1:0] drive_phase_out,
  output logic [1:0] sense_enable_out,
  output logic [1:0] ocp_flag_out,
  // indexer and configuration
  output logic [6:0] position_out,
  output logic [2:0] torque_scale_out,
  output logic [3:0] decay_mode_out,
  output logic auto_decay_out
);
  import stp_pkg::*;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [7:0] BLK_A = 8'(`STP_BLANK_A_CYC);
  localparam logic [7:0] BLK_B = 8'(`STP_BLANK_B_CYC);
  localparam logic [7:0] BLK_C = 8'(`STP_BLANK_C_CYC);
  localparam logic [7:0] BLK_D = 8'(`STP_BLANK_D_CYC);
  localparam logic [19:0] SLEEP_LAST = 20'(SLEEP_CYC - 1);
  localparam logic [19:0] WAKE_LAST = 20'(WAKE_CYC - 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [16:0] pin_meta;
  logic [16:0] pin_sync;
  wire logic [16:0] pin_raw = {sleep_in_low_in, output_enable_low_in,
    step_in, dir_in, auto_decay_select_in, overtemp_in,
    motor_supply_under_in, winding_sense_input_in, fet_limit_in};
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_meta <= `STP_PIN_RST;
      pin_sync <= `STP_PIN_RST;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end
  wire logic sleep_high = pin_sync[`STP_PIN_SLEEP];
  wire logic outputs_off = pin_sync[`STP_PIN_OE];
  wire logic step_s = pin_sync[`STP_PIN_STEP];
  wire logic dir_s = pin_sync[`STP_PIN_DIR];
  wire logic auto_decay_select_s = pin_sync[`STP_PIN_AUTO_DECAY_SELECT];
  wire logic ot_s = pin_sync[`STP_PIN_OT];
  wire logic uv_s = pin_sync[`STP_PIN_UV];
  wire logic [1:0] sense_s = pin_sync[`STP_PIN_SENSE +: 2];
  wire logic [7:0] limit_s = pin_sync[`STP_PIN_LIMIT +: 8];
  // undervoltage acts as a synchronous clear of the mode, auto decay, step and bridge flops
  wire logic lockout = uv_s;

  // ----------------------------------------------------------------
  // tri-level select pins
  // ----------------------------------------------------------------
  stp_tri_t [3:0] tri_lvl;
  wire logic [3:0] tri_above = {decay_select_hi_above_in,
    decay_select_lo_above_in, torque_above_in};
  wire logic [3:0] tri_below = {decay_select_hi_below_in,
    decay_select_lo_below_in, torque_below_in};
  genvar ti;
  for (ti = 0; ti < 4; ti++) begin : g_tri
    stp_tri u_tri (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .above_in(tri_above[ti]),
      .below_in(tri_below[ti]),
      .level_out(tri_lvl[ti])
    );
  end
  // pair weight: 3*first + second, 0/Z/1 = 0/1/2
  wire logic [3:0] torque_idx = 4'(tri_lvl[1]) * 4'h3 + 4'(tri_lvl[0]);
  // the undefined 11 pair falls to the lowest scale
  wire logic [2:0] torque_sel = (torque_idx > 4'h7) ? `STP_TORQUE_MAX :
    torque_idx[2:0];
  wire logic [3:0] decay_idx = 4'(tri_lvl[3]) * 4'h3 + 4'(tri_lvl[2]);

  // ----------------------------------------------------------------
  // sleep and wake sequencing
  // ----------------------------------------------------------------
  stp_mode_t mode;
  stp_mode_t next_mode;
  logic [19:0] mode_cnt;
  logic [19:0] next_mode_cnt;
  always_comb begin
    next_mode = mode;
    next_mode_cnt = mode_cnt + 20'h0_0001;
    case (mode)
      STP_SLEEP: begin
        next_mode_cnt = `STP_CNT_RST;
        if (sleep_high) begin
          next_mode = STP_WAKING;
        end
      end
      STP_WAKING: begin
        if (!sleep_high) begin
          next_mode = STP_SLEEP;
        end else if (mode_cnt >= WAKE_LAST) begin
          next_mode = STP_ACTIVE;
        end
      end
      STP_ACTIVE: begin
        next_mode_cnt = `STP_CNT_RST;
        if (!sleep_high) begin
          next_mode = STP_ENTERING;
        end
      end
      STP_ENTERING: begin
        if (sleep_high) begin
          next_mode = STP_ACTIVE;
        end else if (mode_cnt >= SLEEP_LAST) begin
          next_mode = STP_SLEEP;
        end
      end
      default: next_mode = STP_SLEEP;
    endcase
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode <= STP_SLEEP;
      mode_cnt <= `STP_CNT_RST;
    end else if (lockout) begin
      mode <= STP_SLEEP;
      mode_cnt <= `STP_CNT_RST;
    end else begin
      mode <= next_mode;
      mode_cnt <= next_mode_cnt;
    end
  end
  // indexer and bridges run in ACTIVE and while entering sleep, not while waking
  wire logic awake = (mode == STP_ACTIVE) || (mode == STP_ENTERING);
  wire logic leaving_sleep = (mode == STP_SLEEP) && (next_mode == STP_WAKING);
  wire logic out_live = awake && !lockout;

  // ----------------------------------------------------------------
  // auto decay latch
  // ----------------------------------------------------------------
  logic auto_decay;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      auto_decay <= 1'b0;
    end else if (lockout) begin
      auto_decay <= 1'b0;
    end else if (leaving_sleep) begin
      auto_decay <= auto_decay_select_s;
    end
  end

  // ----------------------------------------------------------------
  // step counting
  // ----------------------------------------------------------------
  logic step_prev;
  logic [6:0] position;
  logic [6:0] applied_pos;
  wire logic step_rise = step_s && !step_prev;
  wire logic [6:0] next_position = dir_s ? position + 7'h01 :
    position - 7'h01;
  // counting continues with outputs off; Hi-Z bridges just skip it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      step_prev <= 1'b0;
      position <= `STP_POS_RST;
      applied_pos <= `STP_POS_RST;
    end else if (lockout) begin
      step_prev <= 1'b0;
      position <= `STP_POS_RST;
      applied_pos <= `STP_POS_RST;
    end else begin
      step_prev <= step_s;
      if (awake && step_rise) begin
        position <= next_position;
      end
      if (awake && !outputs_off) begin
        applied_pos <= position;
      end
    end
  end

  // ----------------------------------------------------------------
  // bridges
  // ----------------------------------------------------------------
  // overtemperature and output disable stop the bridges, not the logic
  wire logic bridge_en = awake && !outputs_off && !ot_s;
  logic [1:0] br_on;
  logic [1:0] br_drive;
  logic [1:0] br_sense;
  logic [1:0] br_ocp;
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_br
    stp_bridge_if bif();
    wire logic [4:0] code = sine_step_code_in[gi];
    // band by step code, torque ordered 100% down to 12.5%
    wire logic [7:0] blank_hi = (torque_sel <= 3'h1) ? BLK_D :
      (torque_sel <= 3'h4) ? BLK_C : (torque_sel <= 3'h6) ? BLK_B : BLK_A;
    wire logic [7:0] blank_mid = (torque_sel <= 3'h2) ? BLK_C :
      (torque_sel <= 3'h5) ? BLK_B : BLK_A;
    wire logic [7:0] blank_low = (torque_sel <= 3'h2) ? BLK_B : BLK_A;
    wire logic [7:0] blank_sel = code[4] ? blank_hi :
      code[3] ? blank_mid : code[2] ? blank_low : BLK_A;
    assign bif.enable = bridge_en;
    assign bif.clr = lockout;
    assign bif.trip = sense_s[gi];
    assign bif.limit = limit_s[gi*4 +: 4];
    assign bif.blank_cyc = blank_sel;
    assign br_on[gi] = bif.on;
    assign br_drive[gi] = bif.drive;
    assign br_sense[gi] = bif.sense_en;
    assign br_ocp[gi] = bif.ocp;
    stp_bridge #(
      .DEGLITCH_CYC(OCP_DEGLITCH_CYC),
      .RETRY_CYC(RETRY_CYC),
      .OFF_CYC(OFF_CYC)
    ) u_br (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .bus(bif.bridge)
    );
  end

  // ----------------------------------------------------------------
  // fault reporting
  // ----------------------------------------------------------------
  // held until drive has restarted; while bridge_en is low overtemperature clears on recovery alone, undervoltage once ACTIVE
  logic uv_seen;
  logic ot_seen;
  wire logic resumed = |br_on || !bridge_en;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      uv_seen <= 1'b0;
      ot_seen <= 1'b0;
    end else begin
      if (uv_s) begin
        uv_seen <= 1'b1;
      end else if ((mode == STP_ACTIVE) && resumed) begin
        uv_seen <= 1'b0;
      end
      if (ot_s) begin
        ot_seen <= 1'b1;
      end else if (resumed) begin
        ot_seen <= 1'b0;
      end
    end
  end
  // no cause is latched: overtemperature and undervoltage hold until drive restarts, overcurrent until its retry ends
  wire logic fault_any = uv_s || uv_seen || ot_s || ot_seen ||
    (|br_ocp);

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_out_low_out <= 1'b1;
      internal_regulator_on_out <= 1'b0;
      asleep_out <= 1'b1;
      bridge_on_out <= 2'h0;
      drive_phase_out <= 2'h0;
      sense_enable_out <= 2'h0;
      ocp_flag_out <= 2'h0;
      position_out <= `STP_POS_RST;
      torque_scale_out <= 3'h0;
      decay_mode_out <= 4'h0;
      auto_decay_out <= 1'b0;
    end else begin
      fault_out_low_out <= !fault_any;
      // regulator stays up through overcurrent and overtemperature
      internal_regulator_on_out <= (mode != STP_SLEEP) && !lockout;
      asleep_out <= mode == STP_SLEEP;
      bridge_on_out <= br_on & {2{out_live}};
      drive_phase_out <= br_drive & {2{out_live}};
      sense_enable_out <= br_sense & {2{out_live}};
      ocp_flag_out <= br_ocp;
      position_out <= applied_pos;
      torque_scale_out <= torque_sel;
      decay_mode_out <= decay_idx;
      auto_decay_out <= auto_decay;
    end
  end
endmodule
`default_nettype wire

// File: design/stp_consts.svh
// stp_consts.svh - constants of the stepper control core.
// assumes a 100 MHz core clock; included by bare name.
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH
// ----------------------------------------------------------------
// clock and time conversion
// ----------------------------------------------------------------
`define STP_CLK_MHZ 100
// least times round up to whole cycles
`define STP_NS2CYC(ns) ((((ns) * `STP_CLK_MHZ) + 999) / 1000)
// ----------------------------------------------------------------
// blanking intervals
// ----------------------------------------------------------------
`define STP_BLANK_A_NS 900
`define STP_BLANK_B_NS 1200
`define STP_BLANK_C_NS 1500
`define STP_BLANK_D_NS 1800
`define STP_BLANK_A_CYC `STP_NS2CYC(`STP_BLANK_A_NS)
`define STP_BLANK_B_CYC `STP_NS2CYC(`STP_BLANK_B_NS)
`define STP_BLANK_C_CYC `STP_NS2CYC(`STP_BLANK_C_NS)
`define STP_BLANK_D_CYC `STP_NS2CYC(`STP_BLANK_D_NS)
// ----------------------------------------------------------------
// protection and mode timing
// ----------------------------------------------------------------
`define STP_OCP_NS 3000
`define STP_RETRY_NS 1600000
`define STP_SLEEP_NS 50000
`define STP_WAKE_NS 1000000
`define STP_OFF_NS 20000
`define STP_OCP_CYC `STP_NS2CYC(`STP_OCP_NS)
`define STP_RETRY_CYC `STP_NS2CYC(`STP_RETRY_NS)
`define STP_SLEEP_CYC `STP_NS2CYC(`STP_SLEEP_NS)
`define STP_WAKE_CYC `STP_NS2CYC(`STP_WAKE_NS)
`define STP_OFF_CYC `STP_NS2CYC(`STP_OFF_NS)
// ----------------------------------------------------------------
// synchronised pin vector layout and reset values
// ----------------------------------------------------------------
`define STP_PIN_SLEEP 16
`define STP_PIN_OE 15
`define STP_PIN_STEP 14
`define STP_PIN_DIR 13
`define STP_PIN_AUTO_DECAY_SELECT 12
`define STP_PIN_OT 11
`define STP_PIN_UV 10
`define STP_PIN_SENSE 8
`define STP_PIN_LIMIT 0
`define STP_PIN_RST 17'h0_0000
`define STP_CNT_RST 20'h0_0000
`define STP_POS_RST 7'h00
`define STP_TORQUE_MAX 3'h7
`endif

// File: design/stp_pkg.sv
// stp_pkg.sv - types shared by the stepper control core.
// assumes nothing beyond a SystemVerilog compiler.
package stp_pkg;
  typedef enum logic [1:0] {STP_SLEEP, STP_WAKING, STP_ACTIVE,
    STP_ENTERING} stp_mode_t;
  typedef enum logic [1:0] {PWM_IDLE, PWM_DRIVE, PWM_DECAY,
    PWM_RETRY} stp_pwm_t;
  // codes 0/1/2 are used as the pin weight in select decoding
  typedef enum logic [1:0] {TRI_LOW, TRI_OPEN, TRI_HIGH} stp_tri_t;
endpackage

// File: design/stp_bridge_if.sv
// stp_bridge_if.sv - signals between the control core and one bridge.
// assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface stp_bridge_if;
  logic enable;
  logic clr;
  logic trip;
  logic [3:0] limit;
  logic [7:0] blank_cyc;
  logic on;
  logic drive;
  logic sense_en;
  logic ocp;
  modport ctrl (output enable, clr, trip, limit, blank_cyc,
    input on, drive, sense_en, ocp);
  modport bridge (input enable, clr, trip, limit, blank_cyc,
    output on, drive, sense_en, ocp);
endinterface
`default_nettype wire

// File: design/stp_tri.sv
// stp_tri.sv - resolves one tri-level select pin into low/open/high.
// assumes two window comparators on the pin, both asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "stp_consts.svh"
module stp_tri (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // window comparators
  input wire logic above_in,
  input wire logic below_in,
  // resolved level
  output var stp_pkg::stp_tri_t level_out
);
  import stp_pkg::*;
  logic [1:0] meta;
  logic [1:0] sync;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= 2'h0;
      sync <= 2'h0;
      level_out <= TRI_OPEN;
    end else begin
      meta <= {above_in, below_in};
      sync <= meta;
      // a pin seen both ways is settling: call it high
      level_out <= sync[1] ? TRI_HIGH : (sync[0] ? TRI_LOW : TRI_OPEN);
    end
  end
endmodule
`default_nettype wire

// File: design/stp_bridge.sv
// stp_bridge.sv - one bridge: off-time PWM, blanking, overcurrent.
// assumes synchronised trip and limit inputs from the control core.
`timescale 1ns/1ps
`default_nettype none
`include "stp_consts.svh"
module stp_bridge #(
  parameter int DEGLITCH_CYC = `STP_OCP_CYC,
  parameter int RETRY_CYC = `STP_RETRY_CYC,
  parameter int OFF_CYC = `STP_OFF_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // link to the control core
  stp_bridge_if.bridge bus
);
  import stp_pkg::*;
  localparam logic [19:0] DEG_CNT = 20'(DEGLITCH_CYC);
  localparam logic [19:0] RETRY_LAST = 20'(RETRY_CYC - 1);
  localparam logic [19:0] OFF_LAST = 20'(OFF_CYC - 1);
  stp_pwm_t state;
  stp_pwm_t next_state;
  logic [19:0] cnt;
  logic [19:0] next_cnt;
  logic [19:0] ocp_cnt;
  logic [19:0] next_ocp_cnt;
  wire logic fets_on = (state == PWM_DRIVE) || (state == PWM_DECAY);
  wire logic blank_done = cnt >= {12'h000, bus.blank_cyc};
  // limit flags only, never the sense path
  wire logic fet_limit = |bus.limit;
  wire logic ocp_hit = fet_limit && fets_on && (ocp_cnt >= DEG_CNT);
  always_comb begin
    next_state = state;
    next_cnt = cnt + 20'h0_0001;
    next_ocp_cnt = (fet_limit && fets_on) ? ocp_cnt + 20'h0_0001 :
      `STP_CNT_RST;
    case (state)
      PWM_IDLE: begin
        next_cnt = `STP_CNT_RST;
        if (bus.enable) begin
          next_state = PWM_DRIVE;
        end
      end
      PWM_DRIVE: begin
        if (!bus.enable) begin
          next_state = PWM_IDLE;
        end else if (blank_done && bus.trip) begin
          next_state = PWM_DECAY;
          next_cnt = `STP_CNT_RST;
        end
      end
      PWM_DECAY: begin
        if (!bus.enable) begin
          next_state = PWM_IDLE;
        end else if (cnt >= OFF_LAST) begin
          next_state = PWM_DRIVE;
          next_cnt = `STP_CNT_RST;
        end
      end
      PWM_RETRY: begin
        if (cnt >= RETRY_LAST) begin
          next_state = PWM_IDLE;
          next_cnt = `STP_CNT_RST;
        end
      end
      default: next_state = PWM_IDLE;
    endcase
    if (ocp_hit) begin
      next_state = PWM_RETRY;
      next_cnt = `STP_CNT_RST;
      next_ocp_cnt = `STP_CNT_RST;
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= PWM_IDLE;
      cnt <= `STP_CNT_RST;
      ocp_cnt <= `STP_CNT_RST;
    end else if (bus.clr) begin
      state <= PWM_IDLE;
      cnt <= `STP_CNT_RST;
      ocp_cnt <= `STP_CNT_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ocp_cnt <= next_ocp_cnt;
    end
  end
  assign bus.on = fets_on;
  assign bus.drive = state == PWM_DRIVE;
  assign bus.sense_en = (state == PWM_DRIVE) && blank_done;
  assign bus.ocp = state == PWM_RETRY;
endmodule
`default_nettype wire

// File: verification/stp_winding_model.sv
// stp_winding_model.sv - current comparators of two windings.
// assumes registered drive phase flags from the core.
`timescale 1ns/1ps
`default_nettype none
module stp_winding_model (
  // clock and mode
  input wire logic clk_in,
  input wire logic trip_en_in,
  // bridge side
  input wire logic [1:0] drive_in,
  output logic [1:0] sense_out
);
  // stiff winding trips at once: only blanking keeps drive alive
  always_ff @(posedge clk_in) begin
    sense_out <= trip_en_in ? drive_in : 2'b00;
  end
endmodule
`default_nettype wire

// File: verification/stp_ctrl_properties.sv
// stp_ctrl_properties.sv - port checks on the stepper control core.
// assumes the bench's short counts: retry 20, wake and sleep 10.
`timescale 1ns/1ps
`default_nettype none
module stp_ctrl_properties (
  // clock, reset and pins
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sleep_in_low_in,
  input wire logic output_enable_low_in,
  input wire logic overtemp_in,
  input wire logic motor_supply_under_in,
  // status and bridges
  input wire logic fault_out_low_out,
  input wire logic internal_regulator_on_out,
  input wire logic asleep_out,
  input wire logic [1:0] bridge_on_out,
  input wire logic [1:0] drive_phase_out,
  input wire logic [1:0] sense_enable_out,
  input wire logic [1:0] ocp_flag_out,
  input wire logic [6:0] position_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence retry_hold;
    ocp_flag_out[0] [*8] ##12 ocp_flag_out[0] ##1 !ocp_flag_out[0];
  endsequence
  sense_gate_a: assert property (
    sense_enable_out[0] |-> drive_phase_out[0]) else $error("sense early");
  drive_min_a: assert property (
    $fell(drive_phase_out[0]) && bridge_on_out[0] |->
      $past(sense_enable_out[0])) else $error("drive phase too short");
  sleep_off_a: assert property (
    asleep_out |-> bridge_on_out == 2'b00 && !internal_regulator_on_out)
    else $error("awake in sleep");
  oe_off_a: assert property (
    output_enable_low_in [*6] |-> bridge_on_out == 2'b00)
    else $error("bridge on disabled");
  ot_off_a: assert property (
    overtemp_in [*6] |-> !fault_out_low_out && bridge_on_out == 2'b00)
    else $error("overtemp missed");
  uv_reset_a: assert property (
    motor_supply_under_in [*6] |-> !fault_out_low_out
      && position_out == 7'h00 && !internal_regulator_on_out)
    else $error("undervoltage missed");
  ocp_off_a: assert property (
    ocp_flag_out[0] && $past(ocp_flag_out[0]) |->
      !bridge_on_out[0] && !fault_out_low_out)
    else $error("bridge on in retry");
  retry_time_a: assert property (
    $rose(ocp_flag_out[0]) |-> retry_hold) else $error("retry length");
  wake_hold_a: assert property (
    asleep_out && $rose(sleep_in_low_in) |-> (bridge_on_out == 2'b00) [*8])
    else $error("outputs moved early");
  sleep_wait_a: assert property (
    $fell(sleep_in_low_in) && bridge_on_out != 2'b00 |-> !asleep_out [*8])
    else $error("sleep entered early");
endmodule
bind stp_ctrl stp_ctrl_properties i_props (.clk_in(clk_in),
  .nrst_in(nrst_in), .sleep_in_low_in(sleep_in_low_in),
  .output_enable_low_in(output_enable_low_in), .overtemp_in(overtemp_in),
  .motor_supply_under_in(motor_supply_under_in),
  .fault_out_low_out(fault_out_low_out), .asleep_out(asleep_out),
  .internal_regulator_on_out(internal_regulator_on_out),
  .bridge_on_out(bridge_on_out), .drive_phase_out(drive_phase_out),
  .sense_enable_out(sense_enable_out), .ocp_flag_out(ocp_flag_out),
  .position_out(position_out));
`default_nettype wire

// File: verification/stp_ctrl_bench.sv
// stp_ctrl_bench.sv - self-checking bench of the control core.
// assumes the winding model on the sense pins; short counts.
`timescale 1ns/1ps
`default_nettype none
module stp_ctrl_bench;
  logic clk_in, nrst_in, sleep_in_low_in, output_enable_low_in, step_in;
  logic dir_in, auto_decay_select_in, overtemp_in, motor_supply_under_in;
  logic decay_select_hi_above_in, decay_select_hi_below_in;
  logic decay_select_lo_above_in, decay_select_lo_below_in, model_trip;
  logic [1:0] torque_above_in, torque_below_in, winding_sense_input_in;
  logic [1:0] bridge_on_out, drive_phase_out, sense_enable_out, ocp_flag_out;
  logic [1:0][4:0] sine_step_code_in;
  logic [7:0] fet_limit_in;
  logic fault_out_low_out, internal_regulator_on_out, asleep_out;
  logic auto_decay_out;
  logic [6:0] position_out, p;
  logic [2:0] torque_scale_out;
  logic [3:0] decay_mode_out;
  int bad_count, n_checks, cycles, n;
  int code[10] = '{31, 20, 16, 31, 15, 8, 12, 7, 4, 3};
  int tq[10] = '{0, 1, 2, 7, 0, 3, 6, 2, 3, 0};
  int bl[10] = '{180, 180, 150, 90, 150, 120, 90, 120, 90, 90};
  stp_ctrl #(.OCP_DEGLITCH_CYC(4), .RETRY_CYC(20), .SLEEP_CYC(10),
    .WAKE_CYC(10), .OFF_CYC(30)) i_stp_ctrl (.clk_in(clk_in),
    .nrst_in(nrst_in), .sleep_in_low_in(sleep_in_low_in),
    .output_enable_low_in(output_enable_low_in), .step_in(step_in),
    .dir_in(dir_in), .auto_decay_select_in(auto_decay_select_in),
    .torque_above_in(torque_above_in), .torque_below_in(torque_below_in),
    .decay_select_hi_above_in(decay_select_hi_above_in),
    .decay_select_hi_below_in(decay_select_hi_below_in),
    .decay_select_lo_above_in(decay_select_lo_above_in),
    .decay_select_lo_below_in(decay_select_lo_below_in),
    .overtemp_in(overtemp_in), .motor_supply_under_in(motor_supply_under_in),
    .winding_sense_input_in(winding_sense_input_in),
    .fet_limit_in(fet_limit_in), .sine_step_code_in(sine_step_code_in),
    .fault_out_low_out(fault_out_low_out), .asleep_out(asleep_out),
    .internal_regulator_on_out(internal_regulator_on_out),
    .bridge_on_out(bridge_on_out), .drive_phase_out(drive_phase_out),
    .sense_enable_out(sense_enable_out), .ocp_flag_out(ocp_flag_out),
    .position_out(position_out), .torque_scale_out(torque_scale_out),
    .decay_mode_out(decay_mode_out), .auto_decay_out(auto_decay_out));
  stp_winding_model i_stp_winding_model (.clk_in(clk_in),
    .trip_en_in(model_trip), .drive_in(drive_phase_out),
    .sense_out(winding_sense_input_in));
  // ----------------
  // helpers: drive at rising edges, look at falling edges
  // ----------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic w1;
    @(negedge clk_in);
  endtask
  function automatic logic [1:0] pin(input int w);
    return (w == 0) ? 2'b01 : (w == 1) ? 2'b00 : 2'b10;
  endfunction
  task automatic sel(input int t, input int d);
    {torque_above_in[1], torque_below_in[1]} <= pin(t / 3);
    {torque_above_in[0], torque_below_in[0]} <= pin(t % 3);
    {decay_select_hi_above_in, decay_select_hi_below_in} <= pin(d / 3);
    {decay_select_lo_above_in, decay_select_lo_below_in} <= pin(d % 3);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic meas(output int m);
    while (drive_phase_out[0] !== 1'b0) w1;
    while (drive_phase_out[0] !== 1'b1) w1;
    m = 0;
    while (sense_enable_out[0] !== 1'b1) begin
      w1;
      m++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test;
    end
  end
  // ----------------
  // tests
  // ----------------
  initial begin
    {nrst_in, sleep_in_low_in, output_enable_low_in, step_in} = 4'h0;
    {dir_in, auto_decay_select_in, overtemp_in} = 3'h0;
    {motor_supply_under_in, fet_limit_in, sine_step_code_in} = 19'h0;
    model_trip = 1'b1;
    sel(4, 0);
    tick(16);
    nrst_in <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      sel(i, i);
      tick(8);
      w1;
      chk(torque_scale_out, (i > 7) ? 7 : i);
      chk(decay_mode_out, i);
      tick(1);
    end
    done("select");
    sel(0, 0);
    sleep_in_low_in <= 1'b1;
    while (bridge_on_out !== 2'b11) w1;
    chk(internal_regulator_on_out, 1);
    chk(auto_decay_out, 0);
    for (int k = 0; k < 10; k++) begin
      tick(1);
      sine_step_code_in <= {5'h00, code[k][4:0]};
      sel(tq[k], 0);
      meas(n);
      meas(n);
      chk(n, bl[k]);
    end
    done("blanking");
    tick(1);
    model_trip <= 1'b0;
    for (int j = 0; j < 8; j += 7) begin
      fet_limit_in <= 8'h01 << j;
      tick(12);
      w1;
      chk(ocp_flag_out, 2'b01 << (j / 4));
      chk(bridge_on_out, 2'b10 >> (j / 4));
      chk(fault_out_low_out, 0);
      tick(1);
      fet_limit_in <= 8'h00;
      tick(40);
      w1;
      chk(ocp_flag_out, 0);
      chk(fault_out_low_out, 1);
      tick(1);
    end
    overtemp_in <= 1'b1;
    tick(8);
    w1;
    chk(bridge_on_out, 0);
    chk(fault_out_low_out, 0);
    tick(1);
    overtemp_in <= 1'b0;
    while (bridge_on_out === 2'b00) w1;
    chk(fault_out_low_out, 0);
    tick(3);
    w1;
    chk(fault_out_low_out, 1);
    done("faults");
    tick(1);
    {output_enable_low_in, dir_in} <= 2'b11;
    tick(8);
    w1;
    p = position_out;
    chk(bridge_on_out, 0);
    chk(internal_regulator_on_out, 1);
    repeat (3) begin
      tick(1);
      step_in <= 1'b1;
      tick(4);
      step_in <= 1'b0;
      tick(3);
    end
    w1;
    chk(position_out, p);
    tick(1);
    output_enable_low_in <= 1'b0;
    tick(8);
    w1;
    chk(position_out, 7'(p + 7'h03));
    tick(1);
    auto_decay_select_in <= 1'b1;
    sleep_in_low_in <= 1'b0;
    while (asleep_out !== 1'b1) w1;
    chk(auto_decay_out, 0);
    chk(internal_regulator_on_out, 0);
    tick(1);
    sleep_in_low_in <= 1'b1;
    while (bridge_on_out !== 2'b11) w1;
    chk(auto_decay_out, 1);
    tick(1);
    motor_supply_under_in <= 1'b1;
    tick(8);
    w1;
    chk(fault_out_low_out, 0);
    chk(position_out, 0);
    tick(1);
    motor_supply_under_in <= 1'b0;
    while (bridge_on_out === 2'b00) w1;
    chk(fault_out_low_out, 0);
    tick(3);
    w1;
    chk(fault_out_low_out, 1);
    done("modes");
    end_of_test;
  end
endmodule
`default_nettype wire
